// ===== common/pcrc_pkg.sv
package pcrc_pkg;

    // Register byte offsets on the APB window
    localparam logic [11:0] RESET_HOLD_OFFSET = 12'h040;
    localparam logic [11:0] TIMER_SOURCE_OFFSET = 12'h044;
    localparam logic [11:0] SWITCH_DONE_OFFSET = 12'h048;
    localparam logic [11:0] PWM_SOURCE_OFFSET = 12'h04c;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h060;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h064;

    // Reset hold bit positions
    localparam int TIMER0_HOLD_BIT = 11;
    localparam int PWM1_HOLD_BIT = 10;
    localparam int PWM0_HOLD_BIT = 9;
    localparam int TWO_WIRE_HOLD_BIT = 8;
    localparam int SERIAL4_HOLD_BIT = 7;
    localparam int SERIAL3_HOLD_BIT = 6;
    localparam int SERIAL2_HOLD_BIT = 5;
    localparam int SERIAL1_HOLD_BIT = 4;
    localparam int SERIAL0_HOLD_BIT = 3;
    localparam int SPI_PORT1_HOLD_BIT = 2;
    localparam int SPI_PORT0_HOLD_BIT = 1;
    localparam int HOLD_MSB = 11;
    localparam int HOLD_LSB = 1;

    // Source field layout
    localparam int TIMER_COUNT = 8;
    localparam int TIMER_SOURCE_MSB = 15;
    localparam int PWM_SOURCE_MSB = 11;
    localparam int PWM_SOURCE_LSB = 8;
    localparam int SWITCH_CHANNELS = 10;
    localparam int DONE_TIMER_LSB = 2;

    // Values after reset
    localparam logic [10:0] RESET_HOLD_RESET = 11'h000;
    localparam logic [15:0] TIMER_SOURCE_RESET = 16'h0000;
    localparam logic [3:0] PWM_SOURCE_RESET = 4'h0;
    localparam logic [9:0] SWITCH_DONE_RESET = 10'h3ff;
    localparam logic [9:0] IRQ_MASK_RESET = 10'h000;

    // Changeover timing in pclk cycles
    localparam int DRAIN_CYCLES = 4;
    localparam int SETTLE_CYCLES = 4;

    typedef enum logic [1:0] {
        PCRC_SRC_PLL = 2'b00,
        PCRC_SRC_RC = 2'b01,
        PCRC_SRC_CRYSTAL = 2'b10
    } pcrc_source_type;

    typedef enum logic [1:0] {
        PCRC_SW_DONE = 2'b00,
        PCRC_SW_DRAIN = 2'b01,
        PCRC_SW_SETTLE = 2'b11
    } pcrc_switch_state_type;

    // Codes 10 and 11 both pick the crystal
    function automatic pcrc_source_type pcrc_decode(input logic [1:0] code);
        if (code[1]) begin
            return PCRC_SRC_CRYSTAL;
        end else if (code[0]) begin
            return PCRC_SRC_RC;
        end else begin
            return PCRC_SRC_PLL;
        end
    endfunction

endpackage

// ===== hdl/pcrc_clock_switch.sv
`timescale 1ns/1ps
module pcrc_clock_switch #(
    parameter int DRAIN = pcrc_pkg::DRAIN_CYCLES,
    parameter int SETTLE = pcrc_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Field as software last wrote it
    input wire logic [1:0] requested_code,
    // Toward the clock tree
    output logic [1:0] applied_source,
    output logic clock_gate,
    // Status
    output logic switch_done,
    output logic done_event
);
    localparam int CNT_W = $clog2((DRAIN > SETTLE ? DRAIN : SETTLE) + 1);

    pcrc_pkg::pcrc_switch_state_type state, next_state;
    pcrc_pkg::pcrc_source_type applied, next_applied;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic next_gate, next_done, next_event;

    always_comb begin
        next_state = state;
        next_applied = applied;
        next_cnt = cnt;
        next_gate = clock_gate;
        next_done = switch_done;
        next_event = 1'b0;
        unique case (state)
            pcrc_pkg::PCRC_SW_DONE: begin
                if (pcrc_pkg::pcrc_decode(requested_code) != applied) begin
                    // Stop the old clock first so no runt pulse reaches the timer or PWM
                    next_done = 1'b0;
                    next_gate = 1'b0;
                    next_cnt = '0;
                    next_state = pcrc_pkg::PCRC_SW_DRAIN;
                end
            end
            pcrc_pkg::PCRC_SW_DRAIN: begin
                if (cnt == CNT_W'(DRAIN - 1)) begin
                    next_applied = pcrc_pkg::pcrc_decode(requested_code);
                    next_cnt = '0;
                    next_state = pcrc_pkg::PCRC_SW_SETTLE;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
            pcrc_pkg::PCRC_SW_SETTLE: begin
                if (cnt == CNT_W'(SETTLE - 1)) begin
                    // A field rewritten meanwhile is caught again from the done state
                    next_gate = 1'b1;
                    next_done = 1'b1;
                    next_event = 1'b1;
                    next_state = pcrc_pkg::PCRC_SW_DONE;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
            default: begin
                next_state = pcrc_pkg::PCRC_SW_DONE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pcrc_pkg::PCRC_SW_DONE;
            applied <= pcrc_pkg::PCRC_SRC_PLL;
            cnt <= '0;
            clock_gate <= 1'b1;
            switch_done <= 1'b1;
            done_event <= 1'b0;
        end else begin
            state <= next_state;
            applied <= next_applied;
            cnt <= next_cnt;
            clock_gate <= next_gate;
            switch_done <= next_done;
            done_event <= next_event;
        end
    end

    assign applied_source = 2'(applied);

endmodule

// ===== hdl/pcrc_top.sv
`timescale 1ns/1ps
module pcrc_top #(
    parameter int DRAIN = pcrc_pkg::DRAIN_CYCLES,
    parameter int SETTLE = pcrc_pkg::SETTLE_CYCLES
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Peripheral reset holds
    output logic timer0_reset_hold,
    output logic pwm1_reset_hold,
    output logic pwm0_reset_hold,
    output logic two_wire_reset_hold,
    output logic serial4_reset_hold,
    output logic serial3_reset_hold,
    output logic serial2_reset_hold,
    output logic serial1_reset_hold,
    output logic serial0_reset_hold,
    output logic spi_port1_reset_hold,
    output logic spi_port0_reset_hold,
    // Kernel clock selection toward the clock tree
    output logic [15:0] timer_source_select,
    output logic [7:0] timer_clock_gate,
    output logic [3:0] pwm_source_select,
    output logic [1:0] pwm_clock_gate
);
    localparam int CH = pcrc_pkg::SWITCH_CHANNELS;

    logic [pcrc_pkg::HOLD_MSB:pcrc_pkg::HOLD_LSB] reset_hold, next_reset_hold;
    logic [pcrc_pkg::TIMER_SOURCE_MSB:0] timer_source, next_timer_source;
    logic [3:0] pwm_source, next_pwm_source;
    logic [CH-1:0] irq_status, next_irq_status;
    logic [CH-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;

    logic [2*CH-1:0] requested_codes;
    logic [2*CH-1:0] applied_codes;
    logic [CH-1:0] gates;
    logic [CH-1:0] switch_done;
    logic [CH-1:0] done_events;

    logic access_wait;
    logic wr_take;
    logic rd_take;
    logic mapped;
    logic [31:0] rd_value;

    // Channels 0/1 are the PWMs, 2..9 the timers, matching the done flag layout
    assign requested_codes = {timer_source, pwm_source};

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : gen_switch
            pcrc_clock_switch #(
                .DRAIN(DRAIN),
                .SETTLE(SETTLE)
            ) u_switch (
                .pclk(pclk),
                .presetn(presetn),
                .requested_code(requested_codes[2*g +: 2]),
                .applied_source(applied_codes[2*g +: 2]),
                .clock_gate(gates[g]),
                .switch_done(switch_done[g]),
                .done_event(done_events[g])
            );
        end
    endgenerate

    // One wait state lets read data and the answer come from flops
    assign access_wait = psel & penable & ~pready;
    assign wr_take = psel & penable & pready & pwrite;
    assign rd_take = psel & penable & pready & ~pwrite;

    always_comb begin
        rd_value = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            pcrc_pkg::RESET_HOLD_OFFSET: begin
                rd_value[pcrc_pkg::HOLD_MSB:pcrc_pkg::HOLD_LSB] = reset_hold;
            end
            pcrc_pkg::TIMER_SOURCE_OFFSET: begin
                rd_value[pcrc_pkg::TIMER_SOURCE_MSB:0] = timer_source;
            end
            pcrc_pkg::SWITCH_DONE_OFFSET: begin
                rd_value[CH-1:0] = switch_done;
            end
            pcrc_pkg::PWM_SOURCE_OFFSET: begin
                rd_value[pcrc_pkg::PWM_SOURCE_MSB:pcrc_pkg::PWM_SOURCE_LSB] = pwm_source;
            end
            pcrc_pkg::IRQ_STATUS_OFFSET: begin
                rd_value[CH-1:0] = irq_status;
            end
            pcrc_pkg::IRQ_MASK_OFFSET: begin
                rd_value[CH-1:0] = irq_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_reset_hold = reset_hold;
        next_timer_source = timer_source;
        next_pwm_source = pwm_source;
        next_irq_mask = irq_mask;
        if (wr_take) begin
            // Done flags and status are read-only; writes there are dropped
            if (paddr == pcrc_pkg::RESET_HOLD_OFFSET) begin
                next_reset_hold = pwdata[pcrc_pkg::HOLD_MSB:pcrc_pkg::HOLD_LSB];
            end
            if (paddr == pcrc_pkg::TIMER_SOURCE_OFFSET) begin
                next_timer_source = pwdata[pcrc_pkg::TIMER_SOURCE_MSB:0];
            end
            if (paddr == pcrc_pkg::PWM_SOURCE_OFFSET) begin
                next_pwm_source = pwdata[pcrc_pkg::PWM_SOURCE_MSB:pcrc_pkg::PWM_SOURCE_LSB];
            end
            if (paddr == pcrc_pkg::IRQ_MASK_OFFSET) begin
                next_irq_mask = pwdata[CH-1:0];
            end
        end
    end

    always_comb begin
        next_irq_status = irq_status;
        if (rd_take && paddr == pcrc_pkg::IRQ_STATUS_OFFSET) begin
            next_irq_status = '0;
        end
        // A completion landing on the clearing read is kept
        next_irq_status = next_irq_status | done_events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_comb begin
        next_pready = access_wait;
        next_pslverr = access_wait & ~mapped;
        next_prdata = 32'h0000_0000;
        if (access_wait && !pwrite) begin
            next_prdata = rd_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_hold <= pcrc_pkg::RESET_HOLD_RESET[pcrc_pkg::HOLD_MSB-1:0];
            timer_source <= pcrc_pkg::TIMER_SOURCE_RESET;
            pwm_source <= pcrc_pkg::PWM_SOURCE_RESET;
            irq_status <= '0;
            irq_mask <= pcrc_pkg::IRQ_MASK_RESET;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            reset_hold <= next_reset_hold;
            timer_source <= next_timer_source;
            pwm_source <= next_pwm_source;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Hold lines are the register bits themselves
    assign timer0_reset_hold = reset_hold[pcrc_pkg::TIMER0_HOLD_BIT];
    assign pwm1_reset_hold = reset_hold[pcrc_pkg::PWM1_HOLD_BIT];
    assign pwm0_reset_hold = reset_hold[pcrc_pkg::PWM0_HOLD_BIT];
    assign two_wire_reset_hold = reset_hold[pcrc_pkg::TWO_WIRE_HOLD_BIT];
    assign serial4_reset_hold = reset_hold[pcrc_pkg::SERIAL4_HOLD_BIT];
    assign serial3_reset_hold = reset_hold[pcrc_pkg::SERIAL3_HOLD_BIT];
    assign serial2_reset_hold = reset_hold[pcrc_pkg::SERIAL2_HOLD_BIT];
    assign serial1_reset_hold = reset_hold[pcrc_pkg::SERIAL1_HOLD_BIT];
    assign serial0_reset_hold = reset_hold[pcrc_pkg::SERIAL0_HOLD_BIT];
    assign spi_port1_reset_hold = reset_hold[pcrc_pkg::SPI_PORT1_HOLD_BIT];
    assign spi_port0_reset_hold = reset_hold[pcrc_pkg::SPI_PORT0_HOLD_BIT];

    assign timer_source_select = applied_codes[2*CH-1:4];
    assign timer_clock_gate = gates[CH-1:pcrc_pkg::DONE_TIMER_LSB];
    assign pwm_source_select = applied_codes[3:0];
    assign pwm_clock_gate = gates[1:0];

endmodule

// ===== tb/pcrc_periph_model.sv
`timescale 1ns/1ps
module pcrc_periph_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Kernel clock selection
    input wire logic [15:0] timer_source_select,
    input wire logic [7:0] timer_clock_gate,
    input wire logic [3:0] pwm_source_select,
    input wire logic [1:0] pwm_clock_gate,
    // Truncated kernel clock pulses seen
    output int glitches
);
    logic [19:0] last_sel;
    logic [19:0] sel;
    logic [9:0] gate;
    assign sel = {pwm_source_select, timer_source_select};
    assign gate = {pwm_clock_gate, timer_clock_gate};
    // A source that moves under a running kernel clock cuts a pulse short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_sel <= 20'h0_0000;
            glitches <= 0;
        end else begin
            last_sel <= sel;
            for (int i = 0; i < 10; i++) begin
                if (sel[2*i+:2] != last_sel[2*i+:2] && gate[i]) begin
                    glitches <= glitches + 1;
                end
            end
        end
    end
endmodule

// ===== tb/pcrc_properties.sv
`timescale 1ns/1ps
module pcrc_checker #(
    parameter int DRAIN = 4,
    parameter int SETTLE = 4
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Reset holds
    input wire logic timer0_reset_hold,
    input wire logic pwm1_reset_hold,
    input wire logic pwm0_reset_hold,
    input wire logic two_wire_reset_hold,
    input wire logic serial4_reset_hold,
    input wire logic serial3_reset_hold,
    input wire logic serial2_reset_hold,
    input wire logic serial1_reset_hold,
    input wire logic serial0_reset_hold,
    input wire logic spi_port1_reset_hold,
    input wire logic spi_port0_reset_hold,
    // Clock selection
    input wire logic [15:0] timer_source_select,
    input wire logic [7:0] timer_clock_gate,
    input wire logic [3:0] pwm_source_select,
    input wire logic [1:0] pwm_clock_gate
);
    // A rewrite during settle starts a second changeover after it, so allow twice the span
    localparam int LOW_MAX = 2 * (DRAIN + SETTLE) + 2;
    logic hold_wr;
    logic [10:0] holds;
    logic [10:0] wr_hold;
    logic [19:0] sels;
    logic [19:0] gate_pairs;
    logic [9:0] gates;
    int low_cycles;
    int next_low_cycles;
    assign hold_wr = psel && penable && pready && pwrite && paddr == 12'h040;
    assign holds = {timer0_reset_hold, pwm1_reset_hold, pwm0_reset_hold, two_wire_reset_hold,
        serial4_reset_hold, serial3_reset_hold, serial2_reset_hold, serial1_reset_hold,
        serial0_reset_hold, spi_port1_reset_hold, spi_port0_reset_hold};
    assign wr_hold = pwdata[11:1];
    assign sels = {pwm_source_select, timer_source_select};
    assign gates = {pwm_clock_gate, timer_clock_gate};
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            gate_pairs[2*i+:2] = {2{gates[i]}};
        end
        next_low_cycles = (gates == 10'h3ff) ? 0 : low_cycles + 1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cycles <= 0;
        end else begin
            low_cycles <= next_low_cycles;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready high two cycles");
    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not after one wait state");
    error_unmapped_a: assert property (pslverr |-> pready
        && !(paddr inside {12'h040, 12'h044, 12'h048, 12'h04c, 12'h060, 12'h064}))
        else $error("error on mapped address");
    read_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    hold_write_a: assert property (hold_wr |=> holds == $past(wr_hold))
        else $error("reset holds differ from write");
    hold_steady_a: assert property (!hold_wr |=> $stable(holds))
        else $error("reset holds moved without write");
    switch_gated_a: assert property (((sels ^ $past(sels)) & gate_pairs) == 20'h0_0000)
        else $error("source moved under running clock");
    no_code11_a: assert property ((sels & (sels >> 1) & 20'h5_5555) == 20'h0_0000)
        else $error("applied source code 11");
    gate_bound_a: assert property (low_cycles <= LOW_MAX)
        else $error("kernel clock gated too long");
    cover property (hold_wr);
    cover property ($fell(pwm_clock_gate[1]));
    cover property (pslverr);
endmodule
bind pcrc_top pcrc_checker #(.DRAIN(DRAIN), .SETTLE(SETTLE)) pcrc_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_reset_hold(timer0_reset_hold), .pwm1_reset_hold(pwm1_reset_hold),
    .pwm0_reset_hold(pwm0_reset_hold), .two_wire_reset_hold(two_wire_reset_hold),
    .serial4_reset_hold(serial4_reset_hold), .serial3_reset_hold(serial3_reset_hold),
    .serial2_reset_hold(serial2_reset_hold), .serial1_reset_hold(serial1_reset_hold),
    .serial0_reset_hold(serial0_reset_hold), .spi_port1_reset_hold(spi_port1_reset_hold),
    .spi_port0_reset_hold(spi_port0_reset_hold), .timer_source_select(timer_source_select),
    .timer_clock_gate(timer_clock_gate), .pwm_source_select(pwm_source_select),
    .pwm_clock_gate(pwm_clock_gate));

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, lf, v;
    logic pready, pslverr, irq, err, sw;
    logic [10:0] holds;
    logic [15:0] tsel, tf, eapp;
    logic [7:0] tgate;
    logic [3:0] psrc;
    logic [1:0] pgate;
    int n_mismatch = 0;
    int checks = 0;
    int glitches, t;
    always #5 pclk = ~pclk;
    pcrc_top pcrc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .timer0_reset_hold(holds[10]),
        .pwm1_reset_hold(holds[9]), .pwm0_reset_hold(holds[8]), .two_wire_reset_hold(holds[7]),
        .serial4_reset_hold(holds[6]), .serial3_reset_hold(holds[5]),
        .serial2_reset_hold(holds[4]), .serial1_reset_hold(holds[3]),
        .serial0_reset_hold(holds[2]), .spi_port1_reset_hold(holds[1]),
        .spi_port0_reset_hold(holds[0]), .timer_source_select(tsel), .timer_clock_gate(tgate),
        .pwm_source_select(psrc), .pwm_clock_gate(pgate));
    pcrc_periph_model pcrc_periph_model_inst (.pclk(pclk), .presetn(presetn),
        .timer_source_select(tsel), .timer_clock_gate(tgate), .pwm_source_select(psrc),
        .pwm_clock_gate(pgate), .glitches(glitches));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] src(input logic [1:0] c);
        return c[1] ? 2'b10 : c;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        if (i >= 20) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task give_verdict;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        lf = 32'h0001_7c21;
        tf = 16'h0000;
        eapp = 16'h0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk({21'h0, holds}, 32'h0000_0000);
        chk({tsel, 6'h00, pgate, tgate}, 32'h0000_03ff);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h044, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h048, 32'hffff_ffff);
        apb(1'b0, 12'h048, 32'h0000_0000);
        chk(rd, 32'h0000_03ff);
        apb(1'b0, 12'h0f0, 32'h0000_0000);
        chk({rd[31:1], err}, 32'h0000_0001);
        $display("test reset_values done");
        for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            v = (k == 4) ? 32'hffff_ffff : (k == 5) ? 32'h0000_0000 : lf;
            apb(1'b1, 12'h040, v);
            // The write lands on the edge the task returns on; look once it has settled
            @(negedge pclk);
            chk({21'h0, holds}, {21'h0, v[11:1]});
            apb(1'b0, 12'h040, 32'h0000_0000);
            chk(rd, v & 32'h0000_0ffe);
        end
        $display("test reset_holds done");
        apb(1'b1, 12'h064, 32'h0000_03ff);
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            t = lf[2:0];
            tf[2*t+:2] = k[1:0];
            sw = src(k[1:0]) != eapp[2*t+:2];
            apb(1'b1, 12'h044, {16'h0000, tf});
            apb(1'b0, 12'h048, 32'h0000_0000);
            chk({31'h0, rd[2+t]}, {31'h0, !sw});
            repeat (pcrc_pkg::DRAIN_CYCLES + pcrc_pkg::SETTLE_CYCLES + 2) @(posedge pclk);
            eapp[2*t+:2] = src(k[1:0]);
            chk({16'h0000, tsel}, {16'h0000, eapp});
            chk({31'h0, irq}, {31'h0, sw});
            apb(1'b0, 12'h060, 32'h0000_0000);
            chk(rd, sw ? (32'h0000_0004 << t) : 32'h0000_0000);
            apb(1'b0, 12'h044, 32'h0000_0000);
            chk(rd, {16'h0000, tf});
        end
        $display("test timer_sources done");
        apb(1'b1, 12'h064, 32'h0000_0000);
        apb(1'b1, 12'h04c, 32'h0000_0c00);
        repeat (pcrc_pkg::DRAIN_CYCLES + pcrc_pkg::SETTLE_CYCLES + 2) @(posedge pclk);
        chk({28'h0, psrc}, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b0, 12'h060, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        // Both PWM channels move at once: pwm1 back to PLL, pwm0 onto the slow RC
        apb(1'b1, 12'h04c, 32'h0000_0100);
        repeat (pcrc_pkg::DRAIN_CYCLES + pcrc_pkg::SETTLE_CYCLES + 2) @(posedge pclk);
        chk({28'h0, psrc}, 32'h0000_0001);
        apb(1'b0, 12'h060, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'b0, 12'h04c, 32'h0000_0000);
        chk(rd, 32'h0000_0100);
        chk(glitches, 32'h0000_0000);
        $display("test pwm_source done");
        give_verdict();
    end
endmodule
